// >>> logic/lta_pkg.sv
// shared constants and types for the light threshold alert logic
// assumes a decoded register port from the serial interface and a conversion engine outside
//
// How it works
// (RULE1) latch select resets to one, picks latched window or transparent hysteresis style
// (RULE2) latch zero: alert and both hit flags follow the latest comparison directly
// (RULE3) latch one: alert and hit flags stay asserted until the host clears them
// (RULE4) invert bit zero, its reset value: alert event pulls the pin low
// (RULE5) invert bit one: pin active high, released during an event for the pull-up
// (RULE6) mask bit one and range below 1100b: result read shows exponent 0000b
// (RULE7) masking touches only the result read value, never the limit comparisons
// (RULE8) fault count select 00/01/10/11 needs 1/2/4/8 consecutive events, resets 00
// (RULE9) low threshold: exponent in 15:12, mantissa in 11:0, both read/write, reset zero
// (RULE10) low threshold in lux is 0.01 times two to the exponent times mantissa
// (RULE11) exponent codes 0000 to 1011 give lsb 0.01 lux doubling to 20.48 lux
// (RULE12) result and both limits scaled to common lux before comparing
// (RULE13) offset 02h holds the lower threshold feeding alert and both flags; here it feeds only the below flag and alert
// (RULE14) above flag sets after selected count of results above the high limit
// (RULE15) below flag sets after selected count of results below the low limit
// (RULE16) a measurement failing a limit's condition restarts that limit's fault counter
package lta_pkg;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [6:0] LTA_OFS_RESULT = 7'h00;
    localparam logic [6:0] LTA_OFS_CONFIG = 7'h01;
    localparam logic [6:0] LTA_OFS_FLOOR = 7'h02;

    // ----------------------------------------------------------------
    // configuration field positions
    // ----------------------------------------------------------------
    localparam int LTA_CFG_RANGE_LSB = 12;
    localparam int LTA_CFG_ABOVE_BIT = 6;
    localparam int LTA_CFG_BELOW_BIT = 5;
    localparam int LTA_CFG_LATCH_BIT = 4;
    localparam int LTA_CFG_INVERT_BIT = 3;
    localparam int LTA_CFG_MASK_BIT = 2;
    localparam int LTA_CFG_FAULT_SEL_LSB = 0;

    // ----------------------------------------------------------------
    // reset values and codes
    // ----------------------------------------------------------------
    localparam logic LTA_LATCH_RST = 1'b1;
    localparam logic LTA_INVERT_RST = 1'b0;
    localparam logic LTA_MASK_RST = 1'b0;
    localparam logic [1:0] LTA_FAULT_SEL_RST = 2'h0;
    localparam logic [15:0] LTA_FLOOR_RST = 16'h0000;
    localparam logic [3:0] LTA_RANGE_AUTO = 4'hC;
    localparam logic [3:0] LTA_EXP_MASKED = 4'h0;
    localparam logic [3:0] LTA_FAULT_MAX = 4'h8;
    localparam int LTA_LUX_W = 27;

    // ----------------------------------------------------------------
    // level carrier: exponent over mantissa, same layout as the registers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [3:0] exponent;
        logic [11:0] mantissa;
    } lta_level_t;

endpackage

// >>> logic/lta_fault_cnt.sv
// consecutive fault counter for one limit
// assumes meas_done is a one-cycle pulse per completed measurement
module lta_fault_cnt (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // measurement
    input wire logic meas_done,
    input wire logic cond,
    input wire logic [1:0] fault_count_sel,
    // trigger, combinational in the meas_done cycle
    output logic trig
);
    import lta_pkg::*;

    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    logic [3:0] cnt_inc;
    logic [3:0] need;

    // ----------------------------------------------------------------
    // count consecutive faults, saturating so a long run keeps triggering
    // ----------------------------------------------------------------
    always_comb begin
        need = 4'(1 << fault_count_sel); // see RULE8
        cnt_inc = (cnt_reg == LTA_FAULT_MAX) ? LTA_FAULT_MAX : 4'(cnt_reg + 4'h1);
        cnt_next = cnt_reg;
        trig = 1'b0;
        if (meas_done) begin
            if (cond) begin
                cnt_next = cnt_inc;
                trig = (cnt_inc >= need); // see RULE8
            end else begin
                cnt_next = 4'h0; // see RULE16
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cnt_reg <= 4'h0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    property p_restart;
        @(posedge ref_clk) disable iff (rst)
        meas_done && !cond |=> cnt_reg == 4'h0;
    endproperty
    a_restart: assert property (p_restart) else $error("fault counter not restarted"); // see RULE16

    property p_single_fault;
        @(posedge ref_clk) disable iff (rst)
        meas_done && cond && fault_count_sel == 2'h0 |-> trig;
    endproperty
    a_single_fault: assert property (p_single_fault) else $error("one fault did not trigger"); // see RULE8

    property p_two_faults;
        @(posedge ref_clk) disable iff (rst)
        meas_done && cond && fault_count_sel == 2'h1 && cnt_reg == 4'h0 |-> !trig;
    endproperty
    a_two_faults: assert property (p_two_faults) else $error("first of two faults triggered"); // see RULE8

endmodule // lta_fault_cnt

// >>> logic/lta_lux_cmp.sv
// converts result and limits to a common lux scale and compares them
// purely combinational; the caller registers what it needs
module lta_lux_cmp (
    // levels
    input lta_pkg::lta_level_t result,
    input lta_pkg::lta_level_t floor_lvl,
    input lta_pkg::lta_level_t ceiling_lvl,
    // comparison
    output logic above,
    output logic below
);
    import lta_pkg::*;

    // lsb weight 0.01 lux doubles per exponent step, so a shift is the whole scale
    function automatic logic [LTA_LUX_W-1:0] to_lux(input lta_level_t lvl);
        logic [LTA_LUX_W-1:0] wide;
        wide = {15'h0000, lvl.mantissa};
        to_lux = wide << lvl.exponent; // see RULE10 see RULE11
    endfunction

    // ----------------------------------------------------------------
    // compare in common units so each side may use its own exponent
    // ----------------------------------------------------------------
    always_comb begin
        above = to_lux(result) > to_lux(ceiling_lvl); // see RULE12
        below = to_lux(result) < to_lux(floor_lvl); // see RULE12
    end

endmodule // lta_lux_cmp

// >>> logic/lta_top.sv
// threshold comparison and alert reporting for the ambient light sensor
// assumes a decoded register port from the serial interface, one access per cycle,
// and a conversion engine that pulses meas_done with a fresh result
module lta_top (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // register port
    input wire logic [6:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // conversion engine
    input wire logic meas_done,
    input lta_pkg::lta_level_t meas_result,
    input wire logic [3:0] range_number,
    input lta_pkg::lta_level_t ceiling_lvl,
    // alert pin, open drain
    output logic alert_pin_o,
    output logic alert_pin_oe,
    // flags
    output logic above_hit,
    output logic below_hit
);
    import lta_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic latch_reg;
    logic latch_next;
    logic invert_reg;
    logic invert_next;
    logic mask_reg;
    logic mask_next;
    logic [1:0] fault_count_sel_reg;
    logic [1:0] fault_count_sel_next;
    lta_level_t floor_reg;
    lta_level_t floor_next;
    logic above_reg;
    logic above_next;
    logic below_reg;
    logic below_next;
    logic alert_oe_reg;
    logic alert_oe_next;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;

    logic hi_cond;
    logic lo_cond;
    logic hi_trig;
    logic lo_trig;
    logic clear_evt;
    logic [3:0] shown_exp;
    logic event_active;

    // ----------------------------------------------------------------
    // comparison and consecutive-fault qualification
    // ----------------------------------------------------------------
    // raw result goes in, so the read mask never bends the comparison
    lta_lux_cmp u_cmp (
        .result(meas_result), // see RULE7
        .floor_lvl(floor_reg), // see RULE13
        .ceiling_lvl(ceiling_lvl),
        .above(hi_cond),
        .below(lo_cond)
    );

    lta_fault_cnt u_hi_cnt (
        .ref_clk(ref_clk),
        .rst(rst),
        .meas_done(meas_done),
        .cond(hi_cond),
        .fault_count_sel(fault_count_sel_reg),
        .trig(hi_trig)
    );

    lta_fault_cnt u_lo_cnt (
        .ref_clk(ref_clk),
        .rst(rst),
        .meas_done(meas_done),
        .cond(lo_cond),
        .fault_count_sel(fault_count_sel_reg),
        .trig(lo_trig)
    );

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    always_comb begin
        latch_next = latch_reg;
        invert_next = invert_reg;
        mask_next = mask_reg;
        fault_count_sel_next = fault_count_sel_reg;
        floor_next = floor_reg;
        if (reg_wr && reg_addr == LTA_OFS_CONFIG) begin
            latch_next = reg_wdata[LTA_CFG_LATCH_BIT]; // see RULE1
            invert_next = reg_wdata[LTA_CFG_INVERT_BIT];
            mask_next = reg_wdata[LTA_CFG_MASK_BIT];
            fault_count_sel_next = reg_wdata[LTA_CFG_FAULT_SEL_LSB +: 2];
        end else if (reg_wr && reg_addr == LTA_OFS_FLOOR) begin
            floor_next = lta_level_t'(reg_wdata); // see RULE9
        end
    end

    // ----------------------------------------------------------------
    // hit flags: a trigger in the clearing cycle wins over the clear
    // ----------------------------------------------------------------
    always_comb begin
        clear_evt = reg_rd && reg_addr == LTA_OFS_CONFIG;
        above_next = above_reg;
        below_next = below_reg;
        if (latch_reg) begin
            if (hi_trig) begin
                above_next = 1'b1; // see RULE14
            end else if (clear_evt) begin
                above_next = 1'b0; // see RULE3
            end
            if (lo_trig) begin
                below_next = 1'b1; // see RULE15
            end else if (clear_evt) begin
                below_next = 1'b0; // see RULE3
            end
        end else if (meas_done) begin
            // transparent: each finished measurement re-decides the flags
            if (hi_trig) begin
                above_next = 1'b1; // see RULE14
            end else if (!hi_cond) begin
                above_next = 1'b0; // see RULE2
            end
            if (lo_trig) begin
                below_next = 1'b1; // see RULE15
            end else if (!lo_cond) begin
                below_next = 1'b0; // see RULE2
            end
        end
        event_active = above_next || below_next;
        // released pin is high through the pull-up, so inversion flips the enable
        alert_oe_next = invert_next ? !event_active : event_active; // see RULE4 see RULE5
    end

    // ----------------------------------------------------------------
    // read data, registered one cycle after the strobe
    // ----------------------------------------------------------------
    always_comb begin
        shown_exp = meas_result.exponent;
        if (mask_reg && range_number < LTA_RANGE_AUTO) begin
            shown_exp = LTA_EXP_MASKED; // see RULE6
        end
        rdata_next = rdata_reg;
        if (reg_rd) begin
            if (reg_addr == LTA_OFS_RESULT) begin
                rdata_next = {shown_exp, meas_result.mantissa}; // see RULE7
            end else if (reg_addr == LTA_OFS_CONFIG) begin
                rdata_next = 16'h0000;
                rdata_next[LTA_CFG_RANGE_LSB +: 4] = range_number;
                rdata_next[LTA_CFG_ABOVE_BIT] = above_reg;
                rdata_next[LTA_CFG_BELOW_BIT] = below_reg;
                rdata_next[LTA_CFG_LATCH_BIT] = latch_reg;
                rdata_next[LTA_CFG_INVERT_BIT] = invert_reg;
                rdata_next[LTA_CFG_MASK_BIT] = mask_reg;
                rdata_next[LTA_CFG_FAULT_SEL_LSB +: 2] = fault_count_sel_reg;
            end else if (reg_addr == LTA_OFS_FLOOR) begin
                rdata_next = floor_reg; // see RULE9
            end else begin
                rdata_next = 16'h0000; // unmapped reads as zero
            end
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            latch_reg <= LTA_LATCH_RST; // see RULE1
            invert_reg <= LTA_INVERT_RST; // see RULE4
            mask_reg <= LTA_MASK_RST; // see RULE6
            fault_count_sel_reg <= LTA_FAULT_SEL_RST; // see RULE8
            floor_reg <= lta_level_t'(LTA_FLOOR_RST); // see RULE9
            above_reg <= 1'b0;
            below_reg <= 1'b0;
            alert_oe_reg <= 1'b0;
            rdata_reg <= 16'h0000;
        end else begin
            latch_reg <= latch_next;
            invert_reg <= invert_next;
            mask_reg <= mask_next;
            fault_count_sel_reg <= fault_count_sel_next;
            floor_reg <= floor_next;
            above_reg <= above_next;
            below_reg <= below_next;
            alert_oe_reg <= alert_oe_next;
            rdata_reg <= rdata_next;
        end
    end

    // pin only ever pulls low; level high comes from the external pull-up
    always_comb begin
        alert_pin_o = 1'b0;
        alert_pin_oe = alert_oe_reg;
        above_hit = above_reg;
        below_hit = below_reg;
        reg_rdata = rdata_reg;
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_latch_reset;
        @(posedge ref_clk) rst |=> latch_reg && !invert_reg && fault_count_sel_reg == 2'h0;
    endproperty
    a_latch_reset: assert property (p_latch_reset) else $error("bad config reset"); // see RULE1

    property p_transparent;
        @(posedge ref_clk) disable iff (rst)
        !latch_reg && meas_done && !hi_cond |=> !above_reg;
    endproperty
    a_transparent: assert property (p_transparent) else $error("transparent above flag stuck"); // see RULE2

    property p_latched_hold;
        @(posedge ref_clk) disable iff (rst)
        latch_reg && below_reg && !clear_evt |=> below_reg;
    endproperty
    a_latched_hold: assert property (p_latched_hold) else $error("latched flag dropped"); // see RULE3

    property p_active_low;
        @(posedge ref_clk) disable iff (rst)
        !invert_reg && (above_reg || below_reg) |-> alert_pin_oe && !alert_pin_o;
    endproperty
    a_active_low: assert property (p_active_low) else $error("alert not pulled low"); // see RULE4

    property p_active_high;
        @(posedge ref_clk) disable iff (rst)
        invert_reg && (above_reg || below_reg) |-> !alert_pin_oe;
    endproperty
    a_active_high: assert property (p_active_high) else $error("alert not released"); // see RULE5

    property p_mask;
        @(posedge ref_clk) disable iff (rst)
        reg_rd && reg_addr == LTA_OFS_RESULT && mask_reg && range_number < 4'hC |=> reg_rdata[15:12] == 4'h0;
    endproperty
    a_mask: assert property (p_mask) else $error("exponent not masked"); // see RULE6

    property p_floor_write;
        @(posedge ref_clk) disable iff (rst)
        reg_wr && reg_addr == LTA_OFS_FLOOR |=> floor_reg == $past(reg_wdata);
    endproperty
    a_floor_write: assert property (p_floor_write) else $error("low threshold not stored"); // see RULE9

    property p_above_set;
        @(posedge ref_clk) disable iff (rst)
        hi_trig |=> above_hit ##0 (alert_pin_oe != invert_reg);
    endproperty
    a_above_set: assert property (p_above_set) else $error("above flag missed"); // see RULE14

    property p_below_set;
        @(posedge ref_clk) disable iff (rst)
        lo_trig |=> below_hit;
    endproperty
    a_below_set: assert property (p_below_set) else $error("below flag missed"); // see RULE15

    property p_below_transparent;
        @(posedge ref_clk) disable iff (rst)
        !latch_reg && meas_done && !lo_cond |=> !below_reg;
    endproperty
    a_below_transparent: assert property (p_below_transparent) else $error("below flag stuck"); // see RULE2

    // a clear with no competing trigger must drop both latched flags
    property p_clear;
        @(posedge ref_clk) disable iff (rst)
        latch_reg && clear_evt && !hi_trig && !lo_trig |=> !above_reg && !below_reg;
    endproperty
    a_clear: assert property (p_clear) else $error("latched flags not cleared"); // see RULE3

    property p_idle_released;
        @(posedge ref_clk) disable iff (rst)
        !invert_reg && !above_reg && !below_reg |-> !alert_pin_oe;
    endproperty
    a_idle_released: assert property (p_idle_released) else $error("alert driven without event"); // see RULE4

    property p_idle_driven;
        @(posedge ref_clk) disable iff (rst)
        invert_reg && !above_reg && !below_reg |-> alert_pin_oe && !alert_pin_o;
    endproperty
    a_idle_driven: assert property (p_idle_driven) else $error("inverted alert not held low"); // see RULE5

    property p_unmasked;
        @(posedge ref_clk) disable iff (rst)
        reg_rd && reg_addr == LTA_OFS_RESULT && !(mask_reg && range_number < LTA_RANGE_AUTO)
        |=> reg_rdata[15:12] == $past(meas_result.exponent);
    endproperty
    a_unmasked: assert property (p_unmasked) else $error("exponent masked without cause"); // see RULE6

    property p_config_hold;
        @(posedge ref_clk) disable iff (rst)
        !(reg_wr && reg_addr == LTA_OFS_CONFIG) |=> $stable(latch_reg) && $stable(fault_count_sel_reg);
    endproperty
    a_config_hold: assert property (p_config_hold) else $error("config changed without write"); // see RULE1

    property p_floor_reset;
        @(posedge ref_clk) rst |=> floor_reg == LTA_FLOOR_RST;
    endproperty
    a_floor_reset: assert property (p_floor_reset) else $error("low threshold not reset"); // see RULE9

endmodule // lta_top

// >>> dv/lta_host_model.sv
// host side model: drives the decoded register port and watches the alert line
// assumes the bench calls wr and rd hierarchically, one access at a time
module lta_host_model (
    // clock
    input wire logic ref_clk,
    // register port
    output logic [6:0] reg_addr,
    output logic [15:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // alert pin
    input wire logic alert_pin_o,
    input wire logic alert_pin_oe,
    output logic alert_line
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------------
    // open drain wire with external pull-up
    // ----------------------------------------------------------------
    assign alert_line = alert_pin_oe ? alert_pin_o : 1'b1;

    initial begin
        reg_addr = 7'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // one write; idle bus shows inverted values so stale data never looks valid
    task wr(input logic [6:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask

    // one read; data taken once the registered answer has landed
    task rd(input logic [6:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        #1;
        d = reg_rdata;
    endtask
endmodule // lta_host_model

// >>> dv/lta_top_tb_top.sv
// self-checking bench for the light threshold alert logic
// assumes the host model for register traffic; measurements driven here
module lta_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import lta_pkg::*;

    typedef struct packed {
        logic [15:0] flo;
        logic [15:0] cei;
        logic [15:0] res;
        logic ab;
        logic be;
    } lta_row_t;

    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic ref_clk, rst, reg_wr, reg_rd, meas_done, alert_pin_o, alert_pin_oe, above_hit, below_hit, alert_line;
    logic [6:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, d;
    logic [3:0] range_number;
    lta_level_t meas_result, ceiling_lvl;
    int error_cnt, n_checks;
    // mixed exponents exercise the common lux scale, including code 1011
    localparam lta_row_t ROWS [5] = '{
        '{16'h1100, 16'hBFFF, 16'h0200, 1'b0, 1'b0},
        '{16'h1100, 16'hBFFF, 16'h01FF, 1'b0, 1'b1},
        '{16'h1100, 16'h2100, 16'h1201, 1'b1, 1'b0},
        '{16'h1100, 16'hB002, 16'hB003, 1'b1, 1'b0},
        '{16'h1100, 16'hB002, 16'h0FFF, 1'b0, 1'b0}};

    lta_top dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .meas_done(meas_done), .meas_result(meas_result),
        .range_number(range_number), .ceiling_lvl(ceiling_lvl), .alert_pin_o(alert_pin_o),
        .alert_pin_oe(alert_pin_oe), .above_hit(above_hit), .below_hit(below_hit));
    lta_host_model host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .alert_pin_o(alert_pin_o), .alert_pin_oe(alert_pin_oe),
        .alert_line(alert_line));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // n back-to-back measurements, then let the flags settle
    task meas(input logic [15:0] r, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge ref_clk);
            meas_done <= 1'b1;
            meas_result <= lta_level_t'(r);
        end
        @(posedge ref_clk);
        meas_done <= 1'b0;
        @(posedge ref_clk);
        #1;
    endtask

    task summarize;
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // watchdog sized well beyond the roughly 190 cycles the tests need
    initial begin
        repeat (20000) @(posedge ref_clk);
        error_cnt++;
        summarize();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        rst = 1'b1;
        meas_done = 1'b0;
        meas_result = lta_level_t'(16'h0000);
        range_number = 4'h3;
        ceiling_lvl = lta_level_t'(16'hBFFF);
        error_cnt = 0;
        n_checks = 0;
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        // reset values, unmapped read and released pin
        host.rd(LTA_OFS_CONFIG, d);
        chk(d, 16'h3010);
        host.rd(LTA_OFS_FLOOR, d);
        chk(d, 16'h0000);
        host.rd(7'h05, d);
        chk(d, 16'h0000);
        chk(alert_line, 1'b1);
        host.wr(LTA_OFS_FLOOR, 16'hA5C3);
        host.rd(LTA_OFS_FLOOR, d);
        chk(d, 16'hA5C3);
        // transparent mode table, single fault count
        host.wr(LTA_OFS_CONFIG, 16'h0000);
        foreach (ROWS[i]) begin
            host.wr(LTA_OFS_FLOOR, ROWS[i].flo);
            ceiling_lvl <= lta_level_t'(ROWS[i].cei);
            meas(ROWS[i].res, 1);
            chk(above_hit, ROWS[i].ab);
            chk(below_hit, ROWS[i].be);
            chk(alert_line, !(ROWS[i].ab | ROWS[i].be));
        end
        // fault count: n-1 hits stay quiet, a miss restarts, the nth hit triggers
        host.wr(LTA_OFS_FLOOR, 16'h0000);
        ceiling_lvl <= lta_level_t'(16'h0100);
        for (int sel = 0; sel < 4; sel++) begin
            host.wr(LTA_OFS_CONFIG, 16'(sel));
            meas(16'h0050, 1);
            meas(16'h0200, (1 << sel) - 1);
            chk(above_hit, 1'b0);
            meas(16'h0050, 1);
            meas(16'h0200, (1 << sel) - 1);
            chk(above_hit, 1'b0);
            meas(16'h0200, 1);
            chk(above_hit, 1'b1);
        end
        // latched mode holds until a config read clears it
        host.wr(LTA_OFS_CONFIG, 16'h0010);
        meas(16'h0050, 1);
        meas(16'h0200, 1);
        meas(16'h0050, 1);
        chk(above_hit, 1'b1);
        chk(alert_line, 1'b0);
        host.rd(LTA_OFS_CONFIG, d);
        chk(d, 16'h3050);
        #5;
        chk(above_hit, 1'b0);
        chk(alert_line, 1'b1);
        // inverted pin: released during the event, driven low otherwise
        host.wr(LTA_OFS_FLOOR, 16'h1100);
        ceiling_lvl <= lta_level_t'(16'hBFFF);
        host.wr(LTA_OFS_CONFIG, 16'h0008);
        meas(16'h0001, 1);
        chk(below_hit, 1'b1);
        chk(alert_line, 1'b1);
        meas(16'h0300, 1);
        chk(alert_line, 1'b0);
        // exponent mask on readback only; range 1011 masks, 1100 does not
        host.wr(LTA_OFS_FLOOR, 16'h0000);
        host.wr(LTA_OFS_CONFIG, 16'h0004);
        range_number <= 4'hB;
        // unmasked level 291 << 5 is above the 512 ceiling, a masked 291 would not be
        ceiling_lvl <= lta_level_t'(16'h0200);
        meas(16'h5123, 1);
        host.rd(LTA_OFS_RESULT, d);
        chk(d, 16'h0123);
        chk(above_hit, 1'b1);
        range_number <= 4'hC;
        host.rd(LTA_OFS_RESULT, d);
        chk(d, 16'h5123);
        host.rd(LTA_OFS_CONFIG, d);
        chk(d, 16'hC044);
        // second reset in mid-run restores defaults
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        host.rd(LTA_OFS_CONFIG, d);
        chk(d, 16'hC010);
        chk(above_hit, 1'b0);
        chk(alert_line, 1'b1);
        summarize();
    end
endmodule // lta_top_tb_top
